// *** include/sfc_defines.vh ***
`ifndef SFC_DEFINES_VH
`define SFC_DEFINES_VH

// ----------------------------------------------------------------------------
// Instruction codes.
// ----------------------------------------------------------------------------
`define SFC_CMD_WREN 8'h06
`define SFC_CMD_WRDI 8'h04
`define SFC_CMD_VWREN 8'h50
`define SFC_CMD_RDSR1 8'h05
`define SFC_CMD_RDSR2 8'h35
`define SFC_CMD_RDSR3 8'h15
`define SFC_CMD_WRSR1 8'h01
`define SFC_CMD_WRSR2 8'h31
`define SFC_CMD_WRSR3 8'h11
`define SFC_CMD_READ 8'h03
`define SFC_CMD_FREAD 8'h0B
`define SFC_CMD_PP 8'h02
`define SFC_CMD_SETPARAM 8'hC0
`define SFC_CMD_ENQPI 8'h38
`define SFC_CMD_EXQPI 8'hFF
`define SFC_CMD_RSTEN 8'h66
`define SFC_CMD_RST 8'h99
`define SFC_CMD_NONE 8'h00

// ----------------------------------------------------------------------------
// Status layout, writable masks and reset values.
// ----------------------------------------------------------------------------
`define SFC_SR1_MASK 8'hFC
`define SFC_SR2_MASK 8'h7B
`define SFC_SR3_MASK 8'hE4
`define SFC_SR2_SRL_BIT 0
`define SFC_SR2_QE_BIT 1
`define SFC_SR2_LB_HI 5
`define SFC_SR2_LB_LO 3
`define SFC_SR1_RESET 8'h00
`define SFC_SR2_RESET 8'h00
`define SFC_SR3_RESET 8'h00
`define SFC_RPARAM_RESET 8'h00

// ----------------------------------------------------------------------------
// Security area decode.
// ----------------------------------------------------------------------------
`define SFC_SEC_HIGH 8'h00
`define SFC_SEC_AREA1 8'h10
`define SFC_SEC_AREA2 8'h20
`define SFC_SEC_AREA3 8'h30

// ----------------------------------------------------------------------------
// Timing counts: dummy counts in link clock rising edges, busy times in core clock cycles.
// ----------------------------------------------------------------------------
`define SFC_FREAD_DUMMY 4'd8
`define SFC_QPI_DUMMY_BASE 4'd2
`define SFC_SR_CYCLES 200
`define SFC_PROG_CYCLES 400

`endif

// *** rtl/sfc_cmd_front.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defines.vh"

module sfc_cmd_front #(
  parameter SR_CYCLES = `SFC_SR_CYCLES,
  parameter PROG_CYCLES = `SFC_PROG_CYCLES
) (
  // Core clock and reset.
  input wire CORE_CLK_IN,
  input wire RESET_IN,
  // Serial link pins.
  input wire SPI_CS_N_IN,
  input wire SPI_CLK_IN,
  input wire [3:0] LANE_IN,
  output reg [3:0] LANE_OUT,
  output reg [3:0] LANE_OE_OUT,
  // Memory array read and write ports.
  output reg [23:0] MEM_ADDR_OUT,
  input wire [7:0] MEM_DATA_IN,
  output reg MEM_WR_OUT,
  output reg [23:0] MEM_WADDR_OUT,
  output reg [7:0] MEM_WDATA_OUT,
  // Device state.
  output reg [1:0] SECURITY_AREA_OUT,
  output reg BUSY_OUT,
  output reg WRITE_LATCH_OUT,
  output reg FOUR_WIRE_MODE_OUT,
  output reg [7:0] READ_PARAM_OUT
);

  // --------------------------------------------------------------------------
  // States and helpers.
  // --------------------------------------------------------------------------
  localparam [5:0] ST_CMD = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_DUMMY = 6'h04;
  localparam [5:0] ST_DOUT = 6'h08;
  localparam [5:0] ST_DIN = 6'h10;
  localparam [5:0] ST_IGN = 6'h20;
  localparam [31:0] SR_LOAD_W = SR_CYCLES - 1;
  localparam [31:0] PROG_LOAD_W = PROG_CYCLES - 1;
  localparam [15:0] SR_LOAD = SR_LOAD_W[15:0];
  localparam [15:0] PROG_LOAD = PROG_LOAD_W[15:0];

  function [7:0] shift_in;
    input [7:0] sh;
    input [3:0] ln;
    input [2:0] w;
    begin
      case (w)
        3'd4: shift_in = {sh[3:0], ln};
        3'd2: shift_in = {sh[5:0], ln[1], ln[0]};
        default: shift_in = {sh[6:0], ln[0]};
      endcase
    end
  endfunction

  function [7:0] merge;
    input [7:0] old;
    input [7:0] data;
    input [7:0] mask;
    begin
      merge = (old & ~mask) | (data & mask);
    end
  endfunction

  function [7:0] merge_sr2;
    input [7:0] old;
    input [7:0] data;
    input vol;
    input four_wire_command_mode;
    reg [7:0] m;
    begin
      m = merge(old, data, `SFC_SR2_MASK);
      m[`SFC_SR2_LB_HI:`SFC_SR2_LB_LO] = m[`SFC_SR2_LB_HI:`SFC_SR2_LB_LO] |
        old[`SFC_SR2_LB_HI:`SFC_SR2_LB_LO];
      if (vol) begin
        m[`SFC_SR2_SRL_BIT] = m[`SFC_SR2_SRL_BIT] | old[`SFC_SR2_SRL_BIT];
      end
      if (four_wire_command_mode) begin
        m[`SFC_SR2_QE_BIT] = old[`SFC_SR2_QE_BIT];
      end
      merge_sr2 = m;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Synchronisers and edge detection.
  // --------------------------------------------------------------------------
  reg cs_s1_r, cs_s2_r, cs_s3_r;
  reg clk_s1_r, clk_s2_r, clk_s3_r;
  reg [3:0] ln_s1_r, ln_s2_r;

  always @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_s3_r <= 1'b0;
      ln_s1_r <= 4'h0;
      ln_s2_r <= 4'h0;
    end else begin
      cs_s1_r <= SPI_CS_N_IN;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      clk_s1_r <= SPI_CLK_IN;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      ln_s1_r <= LANE_IN;
      ln_s2_r <= ln_s1_r;
    end
  end

  wire cs_fall = cs_s3_r & ~cs_s2_r;
  wire cs_rise = ~cs_s3_r & cs_s2_r;
  wire sclk_rise = clk_s2_r & ~clk_s3_r & ~cs_s2_r;
  wire sclk_fall = ~clk_s2_r & clk_s3_r & ~cs_s2_r;

  // --------------------------------------------------------------------------
  // Command state.
  // --------------------------------------------------------------------------
  reg [5:0] st_r;
  reg [7:0] cmd_r, sh_r, d0_r, d1_r, obuf_r, ptr_r;
  reg [2:0] cnt_r;
  reg [3:0] ocnt_r, dcnt_r;
  reg [1:0] abyte_r, din_r;
  reg [23:0] addr_r;
  reg varm_r, rst_arm_r, pend_pp_r;
  reg [15:0] tmr_r;
  reg [7:0] sr1_r, sr2_r, sr3_r, nv1_r, nv2_r, nv3_r, pw1_r, pw2_r, pw3_r;
  reg [2:0] pmask_r;

  wire [2:0] lane_w = FOUR_WIRE_MODE_OUT ? 3'd4 : 3'd1;
  wire [3:0] cnt_sum = {1'b0, cnt_r} + {1'b0, lane_w};
  wire byte_done = cnt_sum[3];
  wire [7:0] sh_new = shift_in(sh_r, ln_s2_r, lane_w);
  wire [23:0] addr_full = {addr_r[15:0], sh_new};
  wire is_mem_read = (cmd_r == `SFC_CMD_READ) || (cmd_r == `SFC_CMD_FREAD);
  wire [7:0] status_byte = (cmd_r == `SFC_CMD_RDSR2) ? sr2_r :
                           (cmd_r == `SFC_CMD_RDSR3) ? sr3_r :
                           {sr1_r[7:2], WRITE_LATCH_OUT, BUSY_OUT};
  wire [7:0] out_src = is_mem_read ? MEM_DATA_IN : status_byte;
  wire [7:0] out_cur = (ocnt_r == 4'd0) ? out_src : obuf_r;
  wire [3:0] qpi_dummy = {1'b0, READ_PARAM_OUT[5:4], 1'b0} + `SFC_QPI_DUMMY_BASE;
  wire [23:0] addr_inc = addr_r + 24'h000001;

  // Status write values: 01h with two data bytes also carries register two.
  wire wr1 = (cmd_r == `SFC_CMD_WRSR1);
  wire wr2 = (cmd_r == `SFC_CMD_WRSR2) || (wr1 && din_r == 2'd2);
  wire wr3 = (cmd_r == `SFC_CMD_WRSR3);
  wire [7:0] d_sr2 = wr1 ? d1_r : d0_r;
  wire [7:0] v1 = wr1 ? merge(sr1_r, d0_r, `SFC_SR1_MASK) : sr1_r;
  wire [7:0] v2 = wr2 ? merge_sr2(sr2_r, d_sr2, 1'b1, FOUR_WIRE_MODE_OUT) : sr2_r;
  wire [7:0] v3 = wr3 ? merge(sr3_r, d0_r, `SFC_SR3_MASK) : sr3_r;
  wire [7:0] n1 = wr1 ? merge(nv1_r, d0_r, `SFC_SR1_MASK) : sr1_r;
  wire [7:0] n2 = wr2 ? merge_sr2(nv2_r, d_sr2, 1'b0, FOUR_WIRE_MODE_OUT) : sr2_r;
  wire [7:0] n3 = wr3 ? merge(nv3_r, d0_r, `SFC_SR3_MASK) : sr3_r;

  always @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      st_r <= ST_CMD;
      cmd_r <= `SFC_CMD_NONE;
      sh_r <= 8'h00;
      d0_r <= 8'h00;
      d1_r <= 8'h00;
      obuf_r <= 8'h00;
      ptr_r <= 8'h00;
      cnt_r <= 3'd0;
      ocnt_r <= 4'd0;
      dcnt_r <= 4'd0;
      abyte_r <= 2'd0;
      din_r <= 2'd0;
      addr_r <= 24'h000000;
      varm_r <= 1'b0;
      rst_arm_r <= 1'b0;
      pend_pp_r <= 1'b0;
      tmr_r <= 16'h0000;
      sr1_r <= `SFC_SR1_RESET;
      sr2_r <= `SFC_SR2_RESET;
      sr3_r <= `SFC_SR3_RESET;
      nv1_r <= `SFC_SR1_RESET;
      nv2_r <= `SFC_SR2_RESET;
      nv3_r <= `SFC_SR3_RESET;
      pw1_r <= 8'h00;
      pw2_r <= 8'h00;
      pw3_r <= 8'h00;
      pmask_r <= 3'b000;
      LANE_OUT <= 4'h0;
      LANE_OE_OUT <= 4'h0;
      MEM_ADDR_OUT <= 24'h000000;
      MEM_WR_OUT <= 1'b0;
      MEM_WADDR_OUT <= 24'h000000;
      MEM_WDATA_OUT <= 8'h00;
      SECURITY_AREA_OUT <= 2'd0;
      BUSY_OUT <= 1'b0;
      WRITE_LATCH_OUT <= 1'b0;
      FOUR_WIRE_MODE_OUT <= 1'b0;
      READ_PARAM_OUT <= `SFC_RPARAM_RESET;
    end else begin
      MEM_WR_OUT <= 1'b0;
      // Self-timed cycle; only status reads can start while it runs.
      if (BUSY_OUT) begin
        if (tmr_r == 16'h0000) begin
          BUSY_OUT <= 1'b0;
          WRITE_LATCH_OUT <= 1'b0;
          pend_pp_r <= 1'b0;
          if (pmask_r != 3'b000) begin
            sr1_r <= pw1_r;
            sr2_r <= pw2_r;
            sr3_r <= pw3_r;
            if (pmask_r[0]) nv1_r <= pw1_r;
            if (pmask_r[1]) nv2_r <= pw2_r;
            if (pmask_r[2]) nv3_r <= pw3_r;
            pmask_r <= 3'b000;
          end
        end else begin
          tmr_r <= tmr_r - 16'h0001;
        end
      end
      if (cs_fall) begin
        st_r <= ST_CMD;
        cnt_r <= 3'd0;
        abyte_r <= 2'd0;
        din_r <= 2'd0;
        ocnt_r <= 4'd0;
      end else if (cs_rise) begin
        // Framed commands take effect when select rises.
        st_r <= ST_CMD;
        LANE_OE_OUT <= 4'h0;
        varm_r <= (cmd_r == `SFC_CMD_VWREN);
        rst_arm_r <= (cmd_r == `SFC_CMD_RSTEN);
        cmd_r <= `SFC_CMD_NONE;
        case (cmd_r)
          `SFC_CMD_WREN: WRITE_LATCH_OUT <= 1'b1;
          `SFC_CMD_WRDI: WRITE_LATCH_OUT <= 1'b0;
          `SFC_CMD_WRSR1, `SFC_CMD_WRSR2, `SFC_CMD_WRSR3: begin
            if (din_r != 2'd0) begin
              if (varm_r) begin
                sr1_r <= v1;
                sr2_r <= v2;
                sr3_r <= v3;
              end else begin
                pw1_r <= n1;
                pw2_r <= n2;
                pw3_r <= n3;
                pmask_r <= {wr3, wr2, wr1};
                BUSY_OUT <= 1'b1;
                tmr_r <= SR_LOAD;
              end
            end
          end
          `SFC_CMD_PP: begin
            if (din_r != 2'd0) begin
              pend_pp_r <= 1'b1;
              BUSY_OUT <= 1'b1;
              tmr_r <= PROG_LOAD;
            end
          end
          `SFC_CMD_SETPARAM: begin
            if (din_r != 2'd0) READ_PARAM_OUT <= d0_r;
          end
          `SFC_CMD_ENQPI: FOUR_WIRE_MODE_OUT <= 1'b1;
          `SFC_CMD_EXQPI: FOUR_WIRE_MODE_OUT <= 1'b0;
          `SFC_CMD_RST: begin
            if (rst_arm_r) begin
              sr1_r <= nv1_r;
              sr2_r <= nv2_r;
              sr3_r <= nv3_r;
              WRITE_LATCH_OUT <= 1'b0;
              READ_PARAM_OUT <= `SFC_RPARAM_RESET;
              FOUR_WIRE_MODE_OUT <= 1'b0;
            end
          end
          default: ;
        endcase
      end else if (sclk_rise) begin
        if (st_r == ST_CMD || st_r == ST_ADDR || st_r == ST_DIN) begin
          sh_r <= sh_new;
          cnt_r <= byte_done ? 3'd0 : cnt_sum[2:0];
        end
        case (st_r)
          ST_CMD: begin
            if (byte_done) begin
              cmd_r <= sh_new;
              st_r <= ST_IGN;
              case (sh_new)
                `SFC_CMD_RDSR1, `SFC_CMD_RDSR2, `SFC_CMD_RDSR3: st_r <= ST_DOUT;
                `SFC_CMD_WREN, `SFC_CMD_WRDI, `SFC_CMD_VWREN, `SFC_CMD_RSTEN, `SFC_CMD_RST: begin
                  if (BUSY_OUT) cmd_r <= `SFC_CMD_NONE;
                end
                `SFC_CMD_WRSR1, `SFC_CMD_WRSR2, `SFC_CMD_WRSR3: begin
                  if (!BUSY_OUT && (WRITE_LATCH_OUT || varm_r)) st_r <= ST_DIN;
                  else cmd_r <= `SFC_CMD_NONE;
                end
                `SFC_CMD_READ: begin
                  if (!BUSY_OUT && !FOUR_WIRE_MODE_OUT) st_r <= ST_ADDR;
                  else cmd_r <= `SFC_CMD_NONE;
                end
                `SFC_CMD_FREAD: begin
                  if (!BUSY_OUT) st_r <= ST_ADDR;
                  else cmd_r <= `SFC_CMD_NONE;
                end
                `SFC_CMD_PP: begin
                  if (!BUSY_OUT && WRITE_LATCH_OUT) st_r <= ST_ADDR;
                  else cmd_r <= `SFC_CMD_NONE;
                end
                `SFC_CMD_SETPARAM: begin
                  if (!BUSY_OUT && FOUR_WIRE_MODE_OUT) st_r <= ST_DIN;
                  else cmd_r <= `SFC_CMD_NONE;
                end
                `SFC_CMD_ENQPI: begin
                  if (BUSY_OUT || FOUR_WIRE_MODE_OUT || !sr2_r[`SFC_SR2_QE_BIT]) cmd_r <= `SFC_CMD_NONE;
                end
                `SFC_CMD_EXQPI: begin
                  if (BUSY_OUT || !FOUR_WIRE_MODE_OUT) cmd_r <= `SFC_CMD_NONE;
                end
                default: cmd_r <= `SFC_CMD_NONE;
              endcase
            end
          end
          ST_ADDR: begin
            if (byte_done) begin
              addr_r <= addr_full;
              abyte_r <= abyte_r + 2'd1;
              if (abyte_r == 2'd2) begin
                MEM_ADDR_OUT <= addr_full;
                ptr_r <= sh_new;
                if (addr_full[23:16] == `SFC_SEC_HIGH && addr_full[15:8] == `SFC_SEC_AREA1)
                  SECURITY_AREA_OUT <= 2'd1;
                else if (addr_full[23:16] == `SFC_SEC_HIGH && addr_full[15:8] == `SFC_SEC_AREA2)
                  SECURITY_AREA_OUT <= 2'd2;
                else if (addr_full[23:16] == `SFC_SEC_HIGH && addr_full[15:8] == `SFC_SEC_AREA3)
                  SECURITY_AREA_OUT <= 2'd3;
                else
                  SECURITY_AREA_OUT <= 2'd0;
                if (cmd_r == `SFC_CMD_READ) begin
                  st_r <= ST_DOUT;
                end else if (cmd_r == `SFC_CMD_FREAD) begin
                  st_r <= ST_DUMMY;
                  dcnt_r <= FOUR_WIRE_MODE_OUT ? qpi_dummy : `SFC_FREAD_DUMMY;
                end else begin
                  st_r <= ST_DIN;
                end
              end
            end
          end
          ST_DUMMY: begin
            dcnt_r <= dcnt_r - 4'd1;
            if (dcnt_r == 4'd1) st_r <= ST_DOUT;
          end
          ST_DIN: begin
            if (byte_done) begin
              if (din_r != 2'd2) din_r <= din_r + 2'd1;
              if (din_r == 2'd0) d0_r <= sh_new;
              if (din_r == 2'd1) d1_r <= sh_new;
              if (cmd_r == `SFC_CMD_PP) begin
                MEM_WR_OUT <= 1'b1;
                MEM_WADDR_OUT <= {addr_r[23:8], ptr_r};
                MEM_WDATA_OUT <= sh_new;
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
          default: ;
        endcase
      end else if (sclk_fall && st_r == ST_DOUT) begin
        // Data leaves on falling edges, upper bits first.
        if (FOUR_WIRE_MODE_OUT) begin
          LANE_OUT <= out_cur[7:4];
          LANE_OE_OUT <= 4'hF;
          obuf_r <= {out_cur[3:0], 4'h0};
          ocnt_r <= (ocnt_r == 4'd4) ? 4'd0 : 4'd4;
        end else begin
          LANE_OUT <= {2'b00, out_cur[7], 1'b0};
          LANE_OE_OUT <= 4'h2;
          obuf_r <= {out_cur[6:0], 1'b0};
          ocnt_r <= (ocnt_r == 4'd7) ? 4'd0 : ocnt_r + 4'd1;
        end
        if (ocnt_r == 4'd0 && is_mem_read) begin
          addr_r <= addr_inc;
          MEM_ADDR_OUT <= addr_inc;
        end
      end
    end
  end

endmodule // sfc_cmd_front

`default_nettype wire

// *** sim/sfc_cmd_front_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Port checker for the command front end.
// ----------------------------------------------------------------------------
module sfc_cmd_front_checker #(
  parameter SR_CYCLES = 200,
  parameter PROG_CYCLES = 400
) (
  // Core clock and reset.
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  // Observed pins and state.
  input wire logic SPI_CS_N_IN,
  input wire logic [3:0] LANE_OE_OUT,
  input wire logic MEM_WR_OUT,
  input wire logic BUSY_OUT,
  input wire logic WRITE_LATCH_OUT,
  input wire logic FOUR_WIRE_MODE_OUT
);
  int busy_cnt_r;

  // Counts how long the self-timed cycle has held busy up.
  always @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) busy_cnt_r <= 0;
    else if (BUSY_OUT) busy_cnt_r <= busy_cnt_r + 1;
    else busy_cnt_r <= 0;
  end

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);

  sequence cs_idle;
    SPI_CS_N_IN [*6];
  endsequence
  sequence busy_ends;
    $fell(BUSY_OUT);
  endsequence

  a_idle_no_drive: assert property (cs_idle |-> LANE_OE_OUT == 4'h0)
    else $error("lanes driven while deselected");
  a_single_lane_oe: assert property ((LANE_OE_OUT != 4'h0 && !FOUR_WIRE_MODE_OUT) |-> LANE_OE_OUT == 4'h2)
    else $error("single mode drives other than lane one");
  a_write_needs_latch: assert property (MEM_WR_OUT |-> WRITE_LATCH_OUT && !BUSY_OUT)
    else $error("array write without write latch");
  a_write_one_pulse: assert property ($rose(MEM_WR_OUT) |=> !MEM_WR_OUT)
    else $error("array write longer than one cycle");
  a_no_write_idle: assert property (SPI_CS_N_IN [*4] |-> !MEM_WR_OUT)
    else $error("array write outside a frame");
  a_busy_clears_latch: assert property (busy_ends |-> !WRITE_LATCH_OUT)
    else $error("write latch still set after busy cycle");
  a_busy_length: assert property (busy_ends |-> (busy_cnt_r == SR_CYCLES || busy_cnt_r == PROG_CYCLES))
    else $error("busy cycle of wrong length");
  a_latch_at_frame_end: assert property ($rose(WRITE_LATCH_OUT) |-> SPI_CS_N_IN && $past(SPI_CS_N_IN, 2))
    else $error("write latch set inside a frame");
endmodule // sfc_cmd_front_checker

`default_nettype wire

// *** sim/sfc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Single-lane and four-wire host: mode 0 frames, link clock low between frames.
// ----------------------------------------------------------------------------
module sfc_host_model (
  // Core clock.
  input wire logic clk_in,
  // Resolved lane levels.
  input wire logic [3:0] wire_in,
  // Link towards the device.
  output logic cs_n_out,
  output logic sclk_out,
  output logic [3:0] lane_out
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    lane_out = 4'h5;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Sends code and nt tail bits, then clocks nr bytes back from lane one.
  task automatic xfer(input logic [7:0] code, input logic [31:0] tail, input int nt, input int nr,
                      output logic [31:0] rd);
    int n;
    logic [39:0] sh;
    n = 8 + nt + 8 * nr;
    sh = {code, 32'(tail << (32 - nt))};
    rd = 32'h0;
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    wait_cyc(4);
    for (int i = 0; i <= n; i++) begin
      if (i > 8 + nt) rd = {rd[30:0], wire_in[1]};
      sclk_out <= 1'b0;
      // Lanes the host does not own keep toggling so no stale level survives.
      lane_out <= {~lane_out[3:1], (i < 8 + nt) ? sh[39] : ~lane_out[0]};
      sh = sh << 1;
      wait_cyc(4);
      if (i < n) begin
        sclk_out <= 1'b1;
        wait_cyc(4);
      end
    end
    cs_n_out <= 1'b1;
    wait_cyc(8);
  endtask

  // Four-wire frame: code and nt tail nibbles, then nr bytes back on all four lanes.
  task automatic xfer4(input logic [7:0] code, input logic [31:0] tail, input int nt, input int nr,
                       output logic [31:0] rd);
    int n;
    logic [39:0] sh;
    n = 2 + nt + 2 * nr;
    sh = {code, 32'(tail << (32 - 4 * nt))};
    rd = 32'h0;
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    wait_cyc(4);
    for (int i = 0; i <= n; i++) begin
      if (i > 2 + nt) rd = {rd[27:0], wire_in};
      sclk_out <= 1'b0;
      lane_out <= (i < 2 + nt) ? sh[39:36] : ~lane_out;
      sh = sh << 4;
      wait_cyc(4);
      if (i < n) begin
        sclk_out <= 1'b1;
        wait_cyc(4);
      end
    end
    cs_n_out <= 1'b1;
    wait_cyc(8);
  endtask
endmodule // sfc_host_model

`default_nettype wire

// *** sim/sfc_cmd_front_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module sfc_cmd_front_tb_top;
  localparam int SR_N = 600;
  localparam int PROG_N = 200;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] mem_data = 8'h00;
  wire logic cs_n, sclk;
  wire logic [3:0] host_lane, lane_wire, lane_out, lane_oe;
  wire logic [23:0] mem_addr, mem_waddr;
  wire logic [7:0] mem_wdata, read_param;
  wire logic [1:0] area;
  wire logic mem_wr, busy, latch, four_wire;
  logic [31:0] rd;
  logic [31:0] last_wr;
  int wr_n = 0;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;

  // ----------------------------------------------------------------------------
  // Clock, array model and lane resolution.
  // ----------------------------------------------------------------------------
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  assign lane_wire = (lane_oe & lane_out) | (~lane_oe & host_lane);
  always @(posedge core_clk) begin
    mem_data <= mem_addr[7:0] ^ 8'h5A;
    if (mem_wr === 1'b1) begin
      last_wr <= {mem_waddr, mem_wdata};
      wr_n <= wr_n + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      print_verdict();
    end
  end

  sfc_cmd_front #(.SR_CYCLES(SR_N), .PROG_CYCLES(PROG_N)) sfc_cmd_front_i (
    .CORE_CLK_IN(core_clk), .RESET_IN(reset), .SPI_CS_N_IN(cs_n), .SPI_CLK_IN(sclk),
    .LANE_IN(lane_wire), .LANE_OUT(lane_out), .LANE_OE_OUT(lane_oe), .MEM_ADDR_OUT(mem_addr),
    .MEM_DATA_IN(mem_data), .MEM_WR_OUT(mem_wr), .MEM_WADDR_OUT(mem_waddr), .MEM_WDATA_OUT(mem_wdata),
    .SECURITY_AREA_OUT(area), .BUSY_OUT(busy), .WRITE_LATCH_OUT(latch),
    .FOUR_WIRE_MODE_OUT(four_wire), .READ_PARAM_OUT(read_param));

  sfc_host_model sfc_host_model_i (
    .clk_in(core_clk), .wire_in(lane_wire), .cs_n_out(cs_n), .sclk_out(sclk), .lane_out(host_lane));

  // ----------------------------------------------------------------------------
  // Tasks.
  // ----------------------------------------------------------------------------
  function automatic logic [7:0] mem(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      n_errors++;
    end
  endtask

  task automatic cmd(input logic [7:0] c, input logic [31:0] t = 0, input int nt = 0, input int nr = 0);
    sfc_host_model_i.xfer(c, t, nt, nr, rd);
  endtask

  task automatic cmd4(input logic [7:0] c, input logic [31:0] t = 0, input int nt = 0, input int nr = 0);
    sfc_host_model_i.xfer4(c, t, nt, nr, rd);
  endtask

  // Reads a status register twice over in one frame.
  task automatic sr(input logic [7:0] c, input logic [7:0] exp);
    cmd(c, 0, 0, 2);
    check(rd[15:0], {exp, exp});
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge core_clk);
      k++;
    end
    check(k < 2000, 1);
    @(posedge core_clk);
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    sr(8'h05, 8'h00);
    check(latch, 0);
    cmd(8'h06);
    check(latch, 1);
    sr(8'h05, 8'h02);
    cmd(8'h04);
    check(latch, 0);
    cmd(8'h01, 8'hFF, 8);
    check(busy, 0);
    sr(8'h05, 8'h00);
    cmd(8'h06);
    cmd(8'h01, 8'hFF, 8);
    check(busy, 1);
    cmd(8'h03, 24'h000010, 24, 1);
    check(mem_addr, 0);
    sr(8'h05, 8'h03);
    wait_idle();
    check(latch, 0);
    sr(8'h05, 8'hFC);
    cmd(8'h06);
    cmd(8'h01, 16'h0002, 16);
    wait_idle();
    sr(8'h35, 8'h02);
    sr(8'h05, 8'h00);
    cmd(8'h06);
    cmd(8'h01, 8'h04, 8);
    wait_idle();
    sr(8'h05, 8'h04);
    sr(8'h35, 8'h02);
    cmd(8'h50);
    check(latch, 0);
    cmd(8'h31, 8'h01, 8);
    check(busy, 0);
    sr(8'h35, 8'h01);
    cmd(8'h50);
    cmd(8'h31, 8'h00, 8);
    sr(8'h35, 8'h01);
    cmd(8'h66);
    cmd(8'h99);
    sr(8'h35, 8'h02);
    sr(8'h05, 8'h04);
    cmd(8'h03, 24'h001234, 24, 2);
    check(rd[15:0], {mem(8'h34), mem(8'h35)});
    check(area, 0);
    for (int a = 1; a <= 3; a++) begin
      cmd(8'h03, {8'h00, 4'(a), 4'h0, 8'h05}, 24, 1);
      check(rd[7:0], mem(8'h05));
      check(area, 32'(a));
    end
    cmd(8'h0B, {24'h0000FE, 8'hFF}, 32, 2);
    check(rd[15:0], {mem(8'hFE), mem(8'hFF)});
    cmd(8'hA5, 32'hFFFFFFFF, 32, 1);
    check({busy, latch}, 0);
    sr(8'h05, 8'h04);
    cmd(8'h02, {24'h000010, 8'h11}, 32);
    check(wr_n, 0);
    cmd(8'h06);
    cmd(8'h02, {24'h000010, 8'h3C}, 32);
    check(wr_n, 1);
    check(last_wr, {24'h000010, 8'h3C});
    check(busy, 1);
    wait_idle();
    check(latch, 0);
    cmd(8'h38);
    check(four_wire, 1);
    cmd4(8'h05, 0, 0, 1);
    check(rd[7:0], 8'h04);
    cmd4(8'h0B, {24'h000040, 8'hFF}, 8, 1);
    check(rd[7:0], mem(8'h40));
    cmd4(8'hC0, 8'h10, 2);
    check(read_param, 8'h10);
    cmd4(8'h50);
    cmd4(8'h31, 8'h00, 2);
    check(busy, 0);
    cmd4(8'h35, 0, 0, 1);
    check(rd[7:0], 8'h02);
    cmd4(8'hFF);
    check(four_wire, 0);
    print_verdict();
  end
endmodule // sfc_cmd_front_tb_top

bind sfc_cmd_front sfc_cmd_front_checker #(.SR_CYCLES(SR_CYCLES), .PROG_CYCLES(PROG_CYCLES)) chk_i (
  .CORE_CLK_IN(CORE_CLK_IN), .RESET_IN(RESET_IN), .SPI_CS_N_IN(SPI_CS_N_IN), .LANE_OE_OUT(LANE_OE_OUT),
  .MEM_WR_OUT(MEM_WR_OUT), .BUSY_OUT(BUSY_OUT), .WRITE_LATCH_OUT(WRITE_LATCH_OUT),
  .FOUR_WIRE_MODE_OUT(FOUR_WIRE_MODE_OUT));

`default_nettype wire
